// *** include/msg_fifo_pkg.sv ***
// Constants and message tables for the event message FIFO.
// Behaviour
// - Messages wait in a first-in first-out buffer of 2048 entries by default.
// - Reading the message register pops the oldest entry, exposing the next one.
// - An empty buffer makes the message register read as zero.
// - A full buffer discards new messages and keeps stored entries.
// - Only message classes enabled in the verbosity setting are stored.
// - Message codes share the command code space; each carries a parameter.
// - Command completion posts its code with status 02, 04 or 09.
// - Network enable is refused with status 04 while no source id is set.
// - Sending a reconfiguration burst posts code 50 under verbosity bit 5.
// - A new upper neighbour posts code 51 with its id, under bit 5.
// - Wrong token destination posts error 52; bad header length posts error 53.
// - An enquiry to this node posts info 54 with the destination id.
// - Sent ack posts 55, sent nak posts 57, both under bit 0.
// - Ack to this node posts info 56; nak to this node posts info 58.
// - A failed token handoff posts code 59 under bit 5.
// - A response timeout after any frame posts info 5a.
// - Each received packet posts 5b to 5e with its fields under bit 4.
// - Receive checksum posts 5f good under bit 4, 60 bad, 61 missing.
// - A received packet shorter than its length posts error 62.
// - A transmitted packet shorter than its length posts error 63.
// - Good transmission posts 65 under bit 4; transmit timeout posts error 66.
package msg_fifo_pkg;
  localparam int FIFO_DEPTH = 2048;
  localparam int CODE_W     = 8;
  localparam int ENTRY_W    = 1 + 2 * CODE_W;
  localparam logic [7:0] ADDR_POP  = 8'h00;
  localparam logic [7:0] ADDR_VERB = 8'h04;
  localparam logic [7:0] ADDR_SID  = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam int STAT_FULL_BIT = 16;
  localparam int STAT_SID_BIT  = 17;
  localparam int VERB_W = 9;
  localparam logic [VERB_W-1:0] VERB_RESET = 9'h1ff;
  localparam logic [3:0] C_B0   = 4'h0;
  localparam logic [3:0] C_B4   = 4'h4;
  localparam logic [3:0] C_B5   = 4'h5;
  localparam logic [3:0] C_ERR  = 4'h6;
  localparam logic [3:0] C_INFO = 4'h7;
  localparam logic [7:0] command_status_success = 8'h02;
  localparam logic [7:0] command_status_refused = 8'h04;
  localparam logic [7:0] command_status_invalid = 8'h09;
  localparam int NUM_EV = 22;
  // Event index order is also the drain priority after the command status.
  localparam logic [7:0] EV_CODE [NUM_EV] = '{
    8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57,
    8'h58, 8'h59, 8'h5a, 8'h5b, 8'h5c, 8'h5d, 8'h5e, 8'h5f,
    8'h60, 8'h61, 8'h62, 8'h63, 8'h65, 8'h66};
  localparam logic [3:0] EV_CLASS [NUM_EV] = '{
    C_B5, C_B5, C_ERR, C_ERR, C_INFO, C_B0, C_INFO, C_B0,
    C_INFO, C_B5, C_INFO, C_B4, C_B4, C_B4, C_B4, C_B4,
    C_ERR, C_ERR, C_ERR, C_ERR, C_B4, C_ERR};
endpackage

// *** core/debug_message_fifo.sv ***
// Event message FIFO with filter, priority drain and AHB-Lite register slave.
//
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module debug_message_fifo
  import msg_fifo_pkg::*;
#(
  parameter int         DEPTH          = FIFO_DEPTH,
  parameter logic [7:0] NET_ENABLE_CMD = 8'h01
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 hsel_i,
  input  wire logic [31:0]          haddr_i,
  input  wire logic [1:0]           htrans_i,
  input  wire logic                 hwrite_i,
  input  wire logic [2:0]           hsize_i,
  input  wire logic [31:0]          hwdata_i,
  input  wire logic                 hready_i,
  output logic      [31:0]          hrdata_o,
  output logic                      hreadyout_o,
  output logic                      hresp_o,
  input  wire logic                 cmd_done_i,
  input  wire logic [7:0]           cmd_code_i,
  input  wire logic [7:0]           cmd_status_i,
  input  wire logic [NUM_EV-1:0]    ev_pulse_i,
  input  wire logic [NUM_EV*8-1:0]  ev_param_i
);
  localparam int AW   = $clog2(DEPTH);
  localparam int NSRC = NUM_EV + 1;
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

  logic [ENTRY_W-1:0] mem [DEPTH];
  logic [AW-1:0]      wr_ptr_r;
  logic [AW-1:0]      rd_ptr_r;
  logic [AW:0]        count_r;
  logic               full;
  logic               empty;
  logic [VERB_W-1:0]  verb_r;
  logic [VERB_W-1:0]  verb_nxt;
  logic [7:0]         sid_r;
  logic               sid_set_r;
  logic               wr_pend_r;
  logic [7:0]         wr_addr_r;
  logic [31:0]        hrdata_r;
  logic [31:0]        rd_nxt;
  logic               a_valid;
  logic               pop;
  logic [NSRC-1:0]    pend_r;
  logic [NSRC-1:0]    set_v;
  logic [7:0]         ppar_r [NSRC];
  logic [7:0]         ccode_r;
  logic [7:0]         cstat;
  logic [4:0]         sel;
  logic               sel_any;
  logic               wr_en;
  logic [ENTRY_W-1:0] wr_word;

  assign full    = (count_r == DEPTH_C);
  assign empty   = (count_r == '0);
  assign a_valid = hsel_i && htrans_i[1] && hready_i;
  assign pop     = a_valid && !hwrite_i && (haddr_i[7:0] == ADDR_POP) && !empty;

  // AHB-Lite slave: zero wait states, always OKAY.
  // Ready stays low in reset, so no transfer is taken before the state is clean.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      hreadyout_o <= 1'b0;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  // The write address is held over for the data phase that carries the word.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= a_valid && hwrite_i;
      wr_addr_r <= haddr_i[7:0];
    end
  end

  // Read data is caught at the address edge and held until the next read.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      hrdata_r <= 32'h0000_0000;
    end else if (a_valid && !hwrite_i) begin
      hrdata_r <= rd_nxt;
    end
  end
  assign hrdata_o = hrdata_r;

  // Writes land in the data phase; a read right behind sees the new verbosity value, but the old source id.
  always_comb begin
    verb_nxt = verb_r;
    if (wr_pend_r && wr_addr_r == ADDR_VERB) begin
      verb_nxt = hwdata_i[VERB_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      verb_r    <= VERB_RESET;
      sid_r     <= 8'h00;
      sid_set_r <= 1'b0;
    end else begin
      verb_r <= verb_nxt;
      if (wr_pend_r && wr_addr_r == ADDR_SID) begin
        sid_r     <= hwdata_i[7:0];
        sid_set_r <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (haddr_i[7:0])
      ADDR_POP: begin
        if (!empty) begin
          rd_nxt = 32'(mem[rd_ptr_r]);
        end
      end
      ADDR_VERB: rd_nxt = 32'(verb_nxt);
      ADDR_SID:  rd_nxt = {23'h0, sid_set_r, sid_r};
      ADDR_STAT: begin
        rd_nxt[AW:0]          = count_r;
        rd_nxt[STAT_FULL_BIT] = full;
        rd_nxt[STAT_SID_BIT]  = sid_set_r;
      end
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // A network enable without a source id is refused whatever the processor said.
  always_comb begin
    cstat = cmd_status_i;
    if (cmd_code_i == NET_ENABLE_CMD && !sid_set_r) begin
      cstat = command_status_refused;
    end
  end

  // Filtering happens at capture, so a masked message never takes a slot.
  always_comb begin
    set_v[0] = cmd_done_i && verb_r[C_INFO] && !full;
    for (int i = 0; i < NUM_EV; i++) begin
      set_v[i+1] = ev_pulse_i[i] && verb_r[EV_CLASS[i]] && !full;
    end
  end

  // Lowest index wins; one message leaves the pending set per cycle.
  always_comb begin
    sel     = 5'd0;
    sel_any = 1'b0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pend_r[i]) begin
        sel     = 5'(i);
        sel_any = 1'b1;
      end
    end
  end

  assign wr_en   = sel_any && !full;
  assign wr_word = (sel == 5'd0) ? {1'b1, ccode_r, ppar_r[0]} :
                   {1'b1, EV_CODE[sel-5'd1],
                    ppar_r[sel]};

  // A new event in the cycle its slot drains is kept, since set beats clear.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pend_r  <= '0;
      ccode_r <= 8'h00;
      for (int i = 0; i < NSRC; i++) begin
        ppar_r[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < NSRC; i++) begin
        pend_r[i] <= set_v[i] || (pend_r[i] && !(sel_any && sel == 5'(i)));
      end
      if (set_v[0]) begin
        ccode_r   <= cmd_code_i;
        ppar_r[0] <= cstat;
      end
      for (int i = 0; i < NUM_EV; i++) begin
        if (set_v[i+1]) begin
          ppar_r[i+1] <= ev_param_i[i*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (wr_en) begin
      mem[wr_ptr_r] <= wr_word;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (wr_en) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      case ({wr_en, pop})
        2'b10:   count_r <= count_r + 1'b1;
        2'b01:   count_r <= count_r - 1'b1;
        default: count_r <= count_r;
      endcase
    end
  end

  chk_depth_bound: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    count_r <= DEPTH_C) else $error("Message count exceeds depth.");

  chk_pop_count: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    pop && !wr_en |=> count_r == $past(count_r) - 1'b1)
    else $error("Pop did not remove one entry.");

  chk_empty_reads_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    a_valid && !hwrite_i && haddr_i[7:0] == ADDR_POP && empty |=> hrdata_o == 32'h0)
    else $error("Empty buffer read as nonzero.");

  chk_full_no_store: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    full && !pop |=> count_r == $past(count_r))
    else $error("Full buffer accepted an entry.");

  chk_filter_masked: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ev_pulse_i[0] && !verb_r[C_B5] && !pend_r[1] |=> !pend_r[1])
    else $error("Masked reconfiguration message was kept.");

  chk_refuse_enable: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cmd_done_i && cmd_code_i == NET_ENABLE_CMD && !sid_set_r && verb_r[C_INFO] && !full
    |=> pend_r[0] && ppar_r[0] == command_status_refused)
    else $error("Network enable without source id not refused.");

  chk_entry_nonzero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wr_en |-> wr_word[ENTRY_W-1] && wr_word != '0)
    else $error("Stored entry encodes as zero.");

  chk_drain_priority: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    pend_r[0] && !full |-> wr_en && wr_word[2*CODE_W-1:CODE_W] == ccode_r)
    else $error("Command status not drained first.");

  chk_store_one: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    pend_r != '0 && !full && !pop |=> count_r == $past(count_r) + 1'b1)
    else $error("Pending message was not stored.");

  chk_zero_wait: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $past(rst_n_i)
    |-> hreadyout_o)
    else $error("Slave inserted a wait state.");

  chk_reset_clean: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !$past(rst_n_i)
    |-> empty && pend_r == '0)
    else $error("Buffer not empty after reset.");

  chk_pop_marker: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    pop
    |=> hrdata_o[ENTRY_W-1] == 1'b1)
    else $error("Popped entry lacks its valid marker.");

  chk_empty_no_move: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    a_valid && !hwrite_i && haddr_i[7:0] == ADDR_POP && empty
    |=> rd_ptr_r == $past(rd_ptr_r))
    else $error("Read of empty buffer moved the read pointer.");

  chk_full_drops: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    full
    |-> set_v == '0)
    else $error("Message captured while buffer full.");

  chk_full_no_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    full
    |-> !wr_en)
    else $error("Write into a full buffer.");

  chk_cmd_masked: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cmd_done_i && !verb_r[C_INFO] && !pend_r[0]
    |=> !pend_r[0])
    else $error("Masked command status was kept.");

  chk_error_masked: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ev_pulse_i[2] && !verb_r[C_ERR] && !pend_r[3]
    |=> !pend_r[3])
    else $error("Masked error message was kept.");

  chk_verb_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wr_pend_r && wr_addr_r == ADDR_VERB
    |=> verb_r == $past(hwdata_i[VERB_W-1:0]))
    else $error("Verbosity write did not land.");

  chk_cmd_status: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cmd_done_i && cmd_code_i != NET_ENABLE_CMD && verb_r[C_INFO] && !full
    |=> ppar_r[0] == $past(cmd_status_i) && ccode_r == $past(cmd_code_i))
    else $error("Command status not captured.");

  chk_sid_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wr_pend_r && wr_addr_r == ADDR_SID
    |=> sid_set_r && sid_r == $past(hwdata_i[7:0]))
    else $error("Source id write did not land.");

  chk_reconfig_kept: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ev_pulse_i[0] && verb_r[C_B5] && !full
    |=> pend_r[1])
    else $error("Reconfiguration message lost.");

  chk_neighbour_param: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ev_pulse_i[1] && verb_r[C_B5] && !full
    |=> pend_r[2] && ppar_r[2] == $past(ev_param_i[15:8]))
    else $error("Neighbour id not captured.");

  chk_enquiry_param: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ev_pulse_i[4] && verb_r[C_INFO] && !full
    |=> pend_r[5] && ppar_r[5] == $past(ev_param_i[39:32]))
    else $error("Enquiry destination not captured.");

  chk_ack_sent_kept: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ev_pulse_i[5] && verb_r[C_B0] && !full
    |=> pend_r[6])
    else $error("Sent acknowledgement message lost.");

  chk_info_masked: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ev_pulse_i[6] && !verb_r[C_INFO] && !pend_r[7]
    |=> !pend_r[7])
    else $error("Masked info message was kept.");

  chk_handoff_kept: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ev_pulse_i[9] && verb_r[C_B5] && !full
    |=> pend_r[10])
    else $error("Token handoff message lost.");

  chk_timeout_kept: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ev_pulse_i[10] && verb_r[C_INFO] && !full
    |=> pend_r[11])
    else $error("Response timeout message lost.");

  chk_rx_field: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ev_pulse_i[11] && verb_r[C_B4] && !full
    |=> pend_r[12] && ppar_r[12] == $past(ev_param_i[95:88]))
    else $error("Received source field not captured.");

  chk_crc_bad_kept: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ev_pulse_i[16] && verb_r[C_ERR] && !full
    |=> pend_r[17])
    else $error("Bad checksum message lost.");

  chk_tx_timeout: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ev_pulse_i[21] && verb_r[C_ERR] && !full
    |=> pend_r[22] && ppar_r[22] == $past(ev_param_i[175:168]))
    else $error("Transmit timeout not captured.");

  chk_status_read: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    a_valid && !hwrite_i && haddr_i[7:0] == ADDR_STAT
    |=> hrdata_o[AW:0] == $past(count_r) && hrdata_o[STAT_FULL_BIT] == $past(full))
    else $error("Status read does not match the fill level.");

  chk_wait_lower: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    pend_r[0] && pend_r[1]
    |=> pend_r[1])
    else $error("Lower priority message dropped while waiting.");

  chk_pend_kept: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    pend_r[NSRC-1] && sel != 5'(NSRC-1)
    |=> pend_r[NSRC-1])
    else $error("Last priority message dropped while waiting.");

  cov_full: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) full);
  cov_pop: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) pop ##1 pop);
  cov_refuse: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cmd_done_i && cmd_code_i == NET_ENABLE_CMD && !sid_set_r);
  cov_burst: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $countones(set_v) > 2);
  cov_drop_full: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    full && ev_pulse_i != '0);
endmodule

// *** sim/testbench.sv ***
// Self-checking testbench for the event message FIFO and its register slave.
`timescale 1ns/1ps
module testbench
  import msg_fifo_pkg::*;
;
  logic                core_clk_i;
  logic                rst_n_i;
  logic [31:0]         haddr_i;
  logic [1:0]          htrans_i;
  logic                hwrite_i;
  logic [31:0]         hwdata_i;
  logic [31:0]         hrdata_o;
  logic                hreadyout_o;
  logic                hresp_o;
  logic                cmd_done_i;
  logic [7:0]          cmd_code_i;
  logic [7:0]          cmd_status_i;
  logic [NUM_EV-1:0]   ev_pulse_i;
  logic [NUM_EV*8-1:0] ev_param_i;
  logic [31:0]         rd;
  int                  fail_count;
  int                  samples_checked;
  localparam logic [7:0] CODES [22] = '{8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56,
    8'h57, 8'h58, 8'h59, 8'h5a, 8'h5b, 8'h5c, 8'h5d, 8'h5e, 8'h5f, 8'h60, 8'h61, 8'h62,
    8'h63, 8'h65, 8'h66};

  // A small depth lets the full-buffer case run in a few cycles.
  debug_message_fifo #(.DEPTH(8)) debug_message_fifo_inst (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .hsel_i(1'b1), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .cmd_done_i(cmd_done_i), .cmd_code_i(cmd_code_i),
    .cmd_status_i(cmd_status_i), .ev_pulse_i(ev_pulse_i), .ev_param_i(ev_param_i));

  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  task automatic test_done();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Waits for hready at a rising edge; a slave that never answers ends the run.
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 50);
    if (hreadyout_o !== 1'b1) begin
      fail_count++;
      test_done();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    htrans_i <= 2'b10;
    haddr_i  <= {24'h0, a};
    hwrite_i <= wr;
    wait_ready();
    htrans_i <= 2'b00;
    hwdata_i <= wd;
    wait_ready();
    rd = hrdata_o;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(name, e, rd);
  endtask

  task automatic ev(input int i, input logic [7:0] p);
    ev_pulse_i[i]       <= 1'b1;
    ev_param_i[8*i +: 8] <= p;
    @(posedge core_clk_i);
    ev_pulse_i <= '0;
    @(posedge core_clk_i);
  endtask

  task automatic cmd(input logic [7:0] c, input logic [7:0] s);
    cmd_done_i   <= 1'b1;
    cmd_code_i   <= c;
    cmd_status_i <= s;
    @(posedge core_clk_i);
    cmd_done_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
  endtask

  function automatic logic [31:0] ent(input logic [7:0] c, input logic [7:0] p);
    return {15'h0, 1'b1, c, p};
  endfunction

  initial begin
    fail_count = 0;
    samples_checked = 0;
    rst_n_i = 1'b0;
    {haddr_i, htrans_i, hwrite_i, hwdata_i} = '0;
    {cmd_done_i, cmd_code_i, cmd_status_i, ev_pulse_i, ev_param_i} = '0;
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rd_chk("empty_pop", 8'h00, 32'h0);
    rd_chk("verbosity", 8'h04, 32'h1ff);
    for (int i = 0; i < 22; i++) begin
      ev(i, 8'h10 + 8'(i));
      repeat (3) @(posedge core_clk_i);
      rd_chk("event", 8'h00, ent(CODES[i], 8'h10 + 8'(i)));
    end
    cmd(8'h20, 8'h09);
    rd_chk("cmd_status", 8'h00, ent(8'h20, 8'h09));
    cmd(8'h01, 8'h02);
    rd_chk("enable_no_id", 8'h00, ent(8'h01, 8'h04));
    bus(1'b1, 8'h08, 32'h33);
    rd_chk("source_id", 8'h08, 32'h0000_0133);
    cmd(8'h01, 8'h02);
    rd_chk("enable_id", 8'h00, ent(8'h01, 8'h02));
    cmd_done_i   <= 1'b1;
    cmd_code_i   <= 8'h21;
    ev_pulse_i   <= 22'h200001;
    @(posedge core_clk_i);
    {cmd_done_i, ev_pulse_i} <= '0;
    repeat (6) @(posedge core_clk_i);
    rd_chk("prio_cmd", 8'h00, ent(8'h21, 8'h02));
    rd_chk("prio_first", 8'h00, ent(8'h50, 8'h10));
    rd_chk("prio_last", 8'h00, ent(8'h66, 8'h25));
    bus(1'b1, 8'h04, 32'h20);
    ev(0, 8'h01);
    ev(5, 8'h02);
    ev(2, 8'h03);
    ev(6, 8'h04);
    repeat (3) @(posedge core_clk_i);
    rd_chk("filter_kept", 8'h00, ent(8'h50, 8'h01));
    rd_chk("filter_drop", 8'h00, 32'h0);
    bus(1'b1, 8'h04, 32'h1ff);
    for (int k = 0; k < 10; k++) ev(11, 8'(k));
    repeat (3) @(posedge core_clk_i);
    rd_chk("status_full", 8'h0c, 32'h0003_0008);
    for (int k = 0; k < 8; k++) rd_chk("full_order", 8'h00, ent(8'h5b, 8'(k)));
    rd_chk("drained", 8'h00, 32'h0);
    check("hresp", 32'h0, {31'h0, hresp_o});
    check("hready", 32'h1, {31'h0, hreadyout_o});
    test_done();
  end
endmodule
